// >>> rtl/p0opt_mem.sv
// Small option store: one word per pin, registered read data.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
module p0opt_mem
    import p0opt_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o,
    output logic      [DEPTH*WIDTH-1:0] all_o
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    for (genvar g = 0; g < DEPTH; g++) begin : g_ent
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                mem_r[g] <= '0;
            end else if (we_i && waddr_i == AW'(g)) begin
                mem_r[g] <= wdata_i;
            end
        end
        assign all_o[g*WIDTH +: WIDTH] = mem_r[g];
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_r[raddr_i];
        end
    end
endmodule

// >>> rtl/p0opt_pkg.sv
// Package for the port 0 pin option block: offsets, fields, codes.
// Assumes a 32-bit APB slave with byte addressing.
package p0opt_pkg;
    localparam int          P0OPT_NPINS          = 8;
    localparam logic [11:0] P0OPT_ACCESS_OFF     = 12'h09e;
    localparam logic [11:0] P0OPT_ACCESS_ADDR    = 12'h278;
    localparam logic [7:0]  P0OPT_ACCESS_RST     = 8'h00;
    localparam int          P0OPT_FUNC_MSB       = 7;
    localparam int          P0OPT_FUNC_LSB       = 5;
    localparam int          P0OPT_DIR_BIT        = 4;
    localparam int          P0OPT_RPTR_BIT       = 3;
    localparam int          P0OPT_IDX_MSB        = 2;
    localparam int          P0OPT_IDX_LSB        = 0;
    localparam logic [2:0]  P0OPT_OUT_NORMAL     = 3'h0;
    localparam logic [2:0]  P0OPT_OUT_HIGH       = 3'h3;
    localparam logic [1:0]  P0OPT_IN_NOPULL      = 2'h0;
    localparam logic [1:0]  P0OPT_IN_PULLDN      = 2'h1;
    localparam logic [1:0]  P0OPT_IN_PULLUP      = 2'h2;
    localparam logic [1:0]  P0OPT_IN_OFF         = 2'h3;
    localparam logic        P0OPT_DIR_OUT        = 1'b0;
endpackage

// >>> rtl/p0opt_top.sv
// Port 0 pin option register, indirectly addressed, behind APB.
// Assumes APB master on clk_i; pin options drive pad controls through one register stage.
`timescale 1ns/1ps
// Behaviour
// - Write with read pointer clear stores function field into indexed pin.
// - Output codes: 000 normal drive, 011 high drive; others illegal.
// - Input codes 00 no pull, 01 pull-down, 10 pull-up, 11 off.
// - Direction bit zero targets output option, one targets input option.
// - Write with read pointer set saves pin index and direction.
// - Write with read pointer set changes no stored option.
// - Read returns selected pin option in function field bits.
// - Index 110 is pin six, 111 is pin seven.
module p0opt_top
    import p0opt_pkg::*;
#(
    parameter int NPINS = P0OPT_NPINS
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [11:0]       paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output logic      [NPINS-1:0]  out_high_drive_o,
    output logic      [NPINS-1:0]  in_buf_en_o,
    output logic      [NPINS-1:0]  in_pull_down_o,
    output logic      [NPINS-1:0]  in_pull_up_o
);
    logic       hit;
    logic       wr_acc;
    logic       rd_setup;
    logic [2:0] function_code_field;
    logic       dir_sel;
    logic       read_ptr_bit;
    logic [2:0] pin_index_field;
    logic       out_we;
    logic       in_we;
    logic [2:0] read_pointer_latch_r;
    logic       read_dir_latch_r;
    logic [2:0] out_rdata;
    logic [1:0] in_rdata;
    logic [NPINS*3-1:0] out_all;
    logic [NPINS*2-1:0] in_all;
    logic [2:0] sel_opt;
    logic       rd_wait_r;
    logic       rd_err_r;

    assign hit      = (paddr_i == P0OPT_ACCESS_ADDR);
    assign wr_acc   = psel_i && penable_i && pwrite_i && pready_o;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;

    assign function_code_field = pwdata_i[P0OPT_FUNC_MSB:P0OPT_FUNC_LSB];
    assign dir_sel             = pwdata_i[P0OPT_DIR_BIT];
    assign read_ptr_bit        = pwdata_i[P0OPT_RPTR_BIT];
    assign pin_index_field     = pwdata_i[P0OPT_IDX_MSB:P0OPT_IDX_LSB];

    // Only the low byte holds the register; other lanes alone do nothing
    assign out_we = wr_acc && hit && pstrb_i[0] && !read_ptr_bit
                    && dir_sel == P0OPT_DIR_OUT;
    assign in_we  = wr_acc && hit && pstrb_i[0] && !read_ptr_bit
                    && dir_sel != P0OPT_DIR_OUT;

    // Illegal output codes are stored as written; software must avoid them
    p0opt_mem #(.WIDTH(3), .DEPTH(NPINS), .AW(3)) u_out_mem (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (out_we),
        .waddr_i (pin_index_field),
        .wdata_i (function_code_field),
        .raddr_i (read_pointer_latch_r),
        .rdata_o (out_rdata),
        .all_o   (out_all)
    );

    p0opt_mem #(.WIDTH(2), .DEPTH(NPINS), .AW(3)) u_in_mem (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (in_we),
        .waddr_i (pin_index_field),
        .wdata_i (function_code_field[1:0]),
        .raddr_i (read_pointer_latch_r),
        .rdata_o (in_rdata),
        .all_o   (in_all)
    );

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            read_pointer_latch_r <= P0OPT_ACCESS_RST[2:0];
            read_dir_latch_r     <= 1'b0;
        end else if (wr_acc && hit && pstrb_i[0] && read_ptr_bit) begin
            read_pointer_latch_r <= pin_index_field;
            read_dir_latch_r     <= dir_sel;
        end
    end

    // Pad controls decoded per pin
    for (genvar p = 0; p < NPINS; p++) begin : g_pin
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                out_high_drive_o[p] <= 1'b0;
                in_buf_en_o[p]      <= 1'b1;
                in_pull_down_o[p]   <= 1'b0;
                in_pull_up_o[p]     <= 1'b0;
            end else begin
                out_high_drive_o[p] <= out_all[p*3 +: 3] == P0OPT_OUT_HIGH;
                in_buf_en_o[p]    <= in_all[p*2 +: 2] != P0OPT_IN_OFF;
                in_pull_down_o[p] <= in_all[p*2 +: 2] == P0OPT_IN_PULLDN;
                in_pull_up_o[p]   <= in_all[p*2 +: 2] == P0OPT_IN_PULLUP;
            end
        end
    end

    // Reads wait one cycle so the store's registered data settles
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_wait_r <= 1'b0;
        end else begin
            rd_wait_r <= rd_setup;
        end
    end

    assign pready_o = !(psel_i && penable_i && !pwrite_i && rd_wait_r);

    assign sel_opt = (read_dir_latch_r == P0OPT_DIR_OUT) ? out_rdata
                     : {1'b0, in_rdata};

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0;
            rd_err_r <= 1'b0;
        end else if (psel_i && penable_i && !pwrite_i && rd_wait_r) begin
            prdata_o <= hit ? {24'h0, sel_opt, 5'h00} : 32'h0;
            rd_err_r <= !hit;
        end else if (psel_i && !penable_i) begin
            rd_err_r <= 1'b0;
        end
    end

    assign pslverr_o = psel_i && penable_i && pready_o
                       && (pwrite_i ? !hit : rd_err_r);

    a_out_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        out_we |=> ##1 (u_out_mem.mem_r[$past(pin_index_field, 2)]
                      == $past(function_code_field, 2)))
        else $error("output option not stored");
    a_in_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        in_we |=> (u_in_mem.mem_r[$past(pin_index_field)]
                   == $past(function_code_field[1:0])))
        else $error("input option not stored");
    a_dir_split: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(out_we && in_we))
        else $error("both options written at once");
    a_ptr_save: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_acc && hit && pstrb_i[0] && read_ptr_bit) |=>
        (read_pointer_latch_r == $past(pin_index_field)
         && read_dir_latch_r == $past(dir_sel)))
        else $error("read pointer not saved");
    a_ptr_nowrite: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_acc && read_ptr_bit) |=> $stable(out_all) && $stable(in_all))
        else $error("option changed by pointer write");
    a_read_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && penable_i && !pwrite_i && rd_wait_r && hit) |=>
        prdata_o[7:5] == $past(sel_opt) && prdata_o[4:0] == 5'h00)
        else $error("read data wrong");
    a_high_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##1 (out_high_drive_o[7] == $past(out_all[23:21] == P0OPT_OUT_HIGH)))
        else $error("pin seven drive wrong");
    a_pull_pin0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##1 (in_pull_up_o[0] == $past(in_all[1:0] == P0OPT_IN_PULLUP)))
        else $error("pin zero pull wrong");

    // Bus timing: writes never stall, reads stall exactly one cycle
    a_wr_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && penable_i && pwrite_i)
        |-> pready_o)
        else $error("write access stalled");
    a_rd_stall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_setup ##1 (psel_i && penable_i && !pwrite_i)
        |-> !pready_o)
        else $error("read access not stalled");
    a_rd_finish: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_setup ##1 (psel_i && penable_i && !pwrite_i)
        |=> pready_o)
        else $error("read access never ends");
    a_rd_wait_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rd_setup
        |=> !rd_wait_r)
        else $error("read wait left armed");
    a_idle_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !psel_i
        |-> pready_o && !pslverr_o)
        else $error("idle bus not ready");

    // Error response only for the unmapped address
    a_wr_slverr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && penable_i && pwrite_i && !hit)
        |-> pslverr_o)
        else $error("unmapped write not flagged");
    a_wr_okay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && penable_i && pwrite_i && hit)
        |-> !pslverr_o)
        else $error("mapped write flagged");
    a_rd_slverr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_setup ##1 (psel_i && penable_i && !pwrite_i && !hit)
        ##1 (psel_i && penable_i)
        |-> pslverr_o)
        else $error("unmapped read not flagged");
    a_rd_okay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_setup ##1 (psel_i && penable_i && !pwrite_i && hit)
        ##1 (psel_i && penable_i)
        |-> !pslverr_o)
        else $error("mapped read flagged");

    // Read data path
    a_rd_unmapped: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && penable_i && !pwrite_i && rd_wait_r && !hit)
        |=> prdata_o == 32'h0)
        else $error("unmapped read data not zero");
    a_rd_spare: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1
        |-> prdata_o[31:8] == 24'h0 && prdata_o[4:0] == 5'h00)
        else $error("spare read bits set");
    a_rd_in_msb: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && penable_i && !pwrite_i && rd_wait_r && hit
         && read_dir_latch_r != P0OPT_DIR_OUT)
        |=> !prdata_o[7])
        else $error("input read msb set");
    a_rd_data_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && penable_i && !pwrite_i && rd_wait_r && hit
         && read_dir_latch_r == P0OPT_DIR_OUT)
        |=> prdata_o[7:5] == $past(out_rdata))
        else $error("output option read wrong");
    a_rd_data_in: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && penable_i && !pwrite_i && rd_wait_r && hit
         && read_dir_latch_r != P0OPT_DIR_OUT)
        |=> prdata_o[6:5] == $past(in_rdata))
        else $error("input option read wrong");
    a_rd_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(psel_i && penable_i && !pwrite_i && rd_wait_r)
        |=> $stable(prdata_o))
        else $error("read data changed early");
    a_out_rdata: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1
        |=> out_rdata == $past(u_out_mem.mem_r[read_pointer_latch_r]))
        else $error("output store read wrong");
    a_in_rdata: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        1'b1
        |=> in_rdata == $past(u_in_mem.mem_r[read_pointer_latch_r]))
        else $error("input store read wrong");

    // Stores change only on a qualified option write
    a_strobe_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_acc && hit && !pstrb_i[0])
        |=> $stable(out_all) && $stable(in_all))
        else $error("option changed without strobe");
    a_no_access: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !wr_acc
        |=> $stable(out_all) && $stable(in_all))
        else $error("option changed without write");
    a_ptr_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(wr_acc && hit && pstrb_i[0] && read_ptr_bit)
        |=> $stable(read_pointer_latch_r) && $stable(read_dir_latch_r))
        else $error("read pointer moved");

    // Index decode at both ends of the range
    a_pin6_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (out_we && pin_index_field == 3'h6)
        |=> u_out_mem.mem_r[6] == $past(function_code_field))
        else $error("pin six output not stored");
    a_pin7_in: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (in_we && pin_index_field == 3'h7)
        |=> u_in_mem.mem_r[7] == $past(function_code_field[1:0]))
        else $error("pin seven input not stored");
    a_pin0_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (out_we && pin_index_field == 3'h0)
        |=> u_out_mem.mem_r[0] == $past(function_code_field))
        else $error("pin zero output not stored");
    a_pin5_in: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (in_we && pin_index_field == 3'h5)
        |=> u_in_mem.mem_r[5] == $past(function_code_field[1:0]))
        else $error("pin five input not stored");

    // Pad decode per pin; pulls must never fight each other
    for (genvar q = 0; q < NPINS; q++) begin : g_chk
        a_pad_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            1'b1
            |=> out_high_drive_o[q]
                == $past(out_all[q*3 +: 3] == P0OPT_OUT_HIGH))
            else $error("drive strength wrong");
        a_pad_buf: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            1'b1
            |=> in_buf_en_o[q]
                == $past(in_all[q*2 +: 2] != P0OPT_IN_OFF))
            else $error("input buffer wrong");
        a_pad_pdn: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            1'b1
            |=> in_pull_down_o[q]
                == $past(in_all[q*2 +: 2] == P0OPT_IN_PULLDN))
            else $error("pull-down wrong");
        a_pad_pup: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            1'b1
            |=> in_pull_up_o[q]
                == $past(in_all[q*2 +: 2] == P0OPT_IN_PULLUP))
            else $error("pull-up wrong");
        a_pull_excl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            !(in_pull_up_o[q] && in_pull_down_o[q]))
            else $error("both pulls on");
    end
endmodule

// >>> verification/port0_pin_option_config_tb.sv
// Self-checking bench for the port 0 pin option register.
// Assumes p0opt_top behind APB on clk_i with sync active-low reset.
`timescale 1ns/1ps
module port0_pin_option_config_tb;
    import p0opt_pkg::*;
    logic        clk_i, rst_n_i, psel, pen, pwr, slverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr;
    logic [7:0]  hd, bufen, pd, pu, ehd, ebuf, epd, epu;
    logic [2:0]  p, c;
    logic        dr;
    int          err_total, total_checks, cyc;
    // Rows: pin, direction, code; pins in ascending order
    logic [6:0]  rows [8] = '{7'h03, 7'h19, 7'h2a, 7'h3b,
                              7'h48, 7'h50, 7'h63, 7'h7a};
    p0opt_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .out_high_drive_o(hd),
        .in_buf_en_o(bufen), .in_pull_down_o(pd), .in_pull_up_o(pu));
    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    task results();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        // Generous ceiling; the run needs well under 1000 cycles
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    // Drive and sample only at rising edges
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
             input logic [3:0] s);
        @(posedge clk_i);
        psel <= 1; pen <= 0; pwr <= w; paddr <= ad; pwdata <= d; pstrb <= s;
        @(posedge clk_i);
        pen <= 1;
        // Request held until pready is seen high at an edge
        do @(posedge clk_i); while (pready !== 1'b1);
        rdata = prdata;
        slverr = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    function automatic logic [31:0] wd(logic [2:0] f, logic d, logic r,
                                       logic [2:0] i);
        return {24'h0, f, d, r, i};
    endfunction
    task rd(input logic [2:0] i, input logic d);
        apb(1, P0OPT_ACCESS_ADDR, wd(3'h7, d, 1'b1, i), 4'hf);
        apb(0, P0OPT_ACCESS_ADDR, 32'h0, 4'hf);
    endtask
    task pads(input string m);
        repeat (2) @(posedge clk_i);
        #1;
        chk({hd, bufen, pd, pu}, {ehd, ebuf, epd, epu}, m);
    endtask
    task do_reset(input int n);
        rst_n_i <= 0;
        repeat (n) @(posedge clk_i);
        rst_n_i <= 1;
        {ehd, ebuf, epd, epu} = {8'h00, 8'hff, 8'h00, 8'h00};
    endtask
    initial begin
        {psel, pen, pwr, paddr, pwdata, pstrb} = '0;
        {err_total, total_checks, cyc} = '0;
        rst_n_i = 0;
        do_reset(5);
        pads("reset pads");
        rd(3'h0, 1'b0);
        chk(rdata, 32'h0, "reset value");
        // Each row writes one pin; full vectors catch spill to others
        for (int i = 0; i < 8; i++) begin
            {p, dr, c} = rows[i];
            apb(1, P0OPT_ACCESS_ADDR, wd(c, dr, 1'b0, p), 4'hf);
            if (dr) begin
                ebuf[p] = (c[1:0] != P0OPT_IN_OFF);
                epd[p] = (c[1:0] == P0OPT_IN_PULLDN);
                epu[p] = (c[1:0] == P0OPT_IN_PULLUP);
            end else
                ehd[p] = (c == P0OPT_OUT_HIGH);
            pads("pad vector");
            rd(p, dr);
            chk(rdata, {24'h0, c, 5'h0}, "readback");
        end
        apb(1, P0OPT_ACCESS_ADDR, wd(3'h7, 1'b0, 1'b1, 3'h0), 4'hf);
        pads("pointer write");
        apb(0, P0OPT_ACCESS_ADDR, 32'h0, 4'hf);
        chk(rdata, 32'h60, "pointer readback");
        rd(3'h0, 1'b1);
        chk(rdata, 32'h0, "other direction");
        apb(1, P0OPT_ACCESS_ADDR, wd(3'h0, 1'b0, 1'b0, 3'h6), 4'hf);
        ehd[6] = 0;
        pads("normal drive");
        apb(1, P0OPT_ACCESS_ADDR, wd(3'h3, 1'b1, 1'b0, 3'h7), 4'he);
        rd(3'h7, 1'b1);
        chk(rdata, 32'h40, "strobe off");
        apb(0, 12'h27c, 32'h0, 4'hf);
        chk(slverr, 1'b1, "unmapped error");
        chk(rdata, 32'h0, "unmapped data");
        @(posedge clk_i);
        do_reset(2);
        pads("second reset");
        rd(3'h6, 1'b0);
        chk(rdata, 32'h0, "cleared option");
        results();
    end
endmodule
